//--- include/ifd_pkg.sv
// Purpose: shared constants for the input terminal function decoder
// Assumes: 8 terminals, 8-bit function codes, APB byte addresses
// Notes: function codes and fault codes are the drive's own numbering
package ifd_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS_DEF = CLK_HZ / MS_PER_S;
    localparam int TERMS = 8;
    localparam int FIFTH_TERM = 4; // index of fifth_input_terminal
    localparam int FC_W = 8;
    localparam int FILT_W = 10;
    localparam logic [FILT_W-1:0] FILT_RST = 10'h00A; // 0.010s in ms
    localparam logic [FILT_W-1:0] FILT_ONE = 10'h001;
    // register byte offsets
    localparam logic [7:0] REG_FUNC_LO = 8'h00;
    localparam logic [7:0] REG_FUNC_HI = 8'h04;
    localparam logic [7:0] REG_CFG = 8'h08;
    localparam logic [7:0] REG_FILT = 8'h0C;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic [7:0] REG_FAULT = 8'h14;
    localparam logic [7:0] REG_EVT = 8'h18;
    localparam logic [7:0] REG_LEN = 8'h1C;
    // configuration fields
    localparam int CFG_SRC_LSB = 0;
    localparam int CFG_PIDDIR_BIT = 2;
    localparam int CFG_PIDMODE_LSB = 3;
    localparam int CFG_UFACT_LSB = 5;
    localparam int CFG_CTRL_BIT = 7;
    localparam logic [31:0] CFG_RST = 32'h0000_0001;
    localparam logic [31:0] FUNC_RST = 32'h0000_0000;
    // command sources
    localparam logic [1:0] SRC_PANEL = 2'h0;
    localparam logic [1:0] SRC_TERM = 2'h1;
    localparam logic [1:0] SRC_COMM = 2'h2;
    localparam logic [1:0] PID_MODE_TERM = 2'h1;
    // function codes 20..46
    localparam logic [7:0] FC_FIRST = 8'h14;
    localparam logic [7:0] FC_CMD_SW = 8'h14;
    localparam logic [7:0] FC_RAMP_HOLD = 8'h15;
    localparam logic [7:0] FC_PID_OFF = 8'h16;
    localparam logic [7:0] FC_PLC_PAUSE = 8'h17;
    localparam logic [7:0] FC_SWING = 8'h18;
    localparam logic [7:0] FC_EVT_IN = 8'h19;
    localparam logic [7:0] FC_EVT_CLR = 8'h1A;
    localparam logic [7:0] FC_LEN_IN = 8'h1B;
    localparam logic [7:0] FC_LEN_CLR = 8'h1C;
    localparam logic [7:0] FC_TQ_INH = 8'h1D;
    localparam logic [7:0] FC_PULSE = 8'h1E;
    localparam logic [7:0] FC_DC_BRAKE = 8'h20;
    localparam logic [7:0] FC_EXT_FLT = 8'h21;
    localparam logic [7:0] FC_FREQ_LOCK = 8'h22;
    localparam logic [7:0] FC_PID_REV = 8'h23;
    localparam logic [7:0] FC_EXT_STOP = 8'h24;
    localparam logic [7:0] FC_CMD_SW2 = 8'h25;
    localparam logic [7:0] FC_INT_FRZ = 8'h26;
    localparam logic [7:0] FC_X_PRESET = 8'h27;
    localparam logic [7:0] FC_Y_PRESET = 8'h28;
    localparam logic [7:0] FC_MOTOR1 = 8'h29;
    localparam logic [7:0] FC_MOTOR2 = 8'h2A;
    localparam logic [7:0] FC_PID_SET = 8'h2B;
    localparam logic [7:0] FC_UFLT1 = 8'h2C;
    localparam logic [7:0] FC_UFLT2 = 8'h2D;
    localparam logic [7:0] FC_SPD_TQ = 8'h2E;
    localparam int FC_SPAN = 27;
    // fault codes and sticky bit positions
    localparam logic [7:0] EXTERNAL_FAULT_CODE = 8'h0F;
    localparam logic [7:0] USER_FAULT_ONE_CODE = 8'h1B;
    localparam logic [7:0] USER_FAULT_TWO_CODE = 8'h1C;
    localparam logic [7:0] NO_FAULT_CODE = 8'h00;
    localparam int FLT_EXT = 0;
    localparam int FLT_U1 = 1;
    localparam int FLT_U2 = 2;
    localparam int FLT_N = 3;
    localparam int CNT_W = 16;
endpackage

//--- src/ifd_decoder.sv
// Purpose: decode debounced input terminals into drive control actions
// Assumes: terminals are asynchronous contacts, ON is high
// Notes: APB slave answers two cycles after setup; ce freezes everything
//
// Overview of operation
// [RULE1] code 20 swaps owner with panel
// [RULE2] code 21 holds frequency, stop still works
// [RULE3] code 22 pauses PID, holds frequency
// [RULE4] code 23 pauses program, resumes on release
// [RULE5] code 24 pauses swing, central frequency out
// [RULE6] code 25 counts pulses on event counter
// [RULE7] code 26 clears event counter
// [RULE8] codes 27/28 count and clear length
// [RULE9] code 29 forces speed control mode
// [RULE10] code 30 honoured only on fifth terminal
// [RULE11] code 32 enters DC braking at once
// [RULE12] code 33 raises external fault and stops
// [RULE13] code 34 locks frequency setpoint
// [RULE14] code 35 inverts PID direction
// [RULE15] code 36 stops like panel stop key
// [RULE16] code 37 hands terminal ownership to communication
// [RULE17] code 38 freezes PID integral only
// [RULE18] codes 39/40 replace X/Y with preset
// [RULE19] codes 41/42 select motor group
// [RULE20] code 43 picks PID set in mode one
// [RULE21] codes 44/45 raise user faults
// [RULE22] code 46 swaps default speed/torque mode
// [RULE23] each terminal debounced by filter time
// [RULE24] terminals synchronised, routed by function code
// [RULE25] reserved or unassigned codes do nothing
`timescale 1ns/100ps
module ifd_decoder
    import ifd_pkg::*;
#(
    parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [TERMS-1:0] term_in,
    output logic [1:0] cmd_owner,
    output logic ramp_hold,
    output logic freq_hold,
    output logic pid_pause,
    output logic plc_pause,
    output logic plc_resume,
    output logic swing_pause,
    output logic [CNT_W-1:0] evt_count,
    output logic [CNT_W-1:0] len_count,
    output logic torque_mode,
    output logic pulse_train,
    output logic dc_brake,
    output logic fault_stop,
    output logic [7:0] fault_code,
    output logic [1:0] fault_action,
    output logic freq_lock,
    output logic pid_reverse,
    output logic panel_stop,
    output logic pid_int_freeze,
    output logic x_preset,
    output logic y_preset,
    output logic [1:0] motor_sel,
    output logic pid_set_two
);
    localparam int MSW = $clog2(CYC_PER_MS + 1);
    localparam logic [MSW-1:0] MS_LAST = MSW'(CYC_PER_MS - 1);
    localparam logic [MSW-1:0] MS_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    logic [TERMS-1:0] sync_a;
    logic [TERMS-1:0] sync_b;
    logic [TERMS-1:0] term_st;
    logic [FILT_W-1:0] dbn_cnt [TERMS];
    logic [MSW-1:0] ms_cnt;
    logic ms_tick;
    logic [FC_W*TERMS-1:0] func_map;
    logic [31:0] cfg;
    logic [FILT_W-1:0] filt_ms;
    logic [FLT_N-1:0] flt;
    logic [FLT_N-1:0] next_flt;
    logic [FLT_N-1:0] flt_set;
    logic [FLT_N-1:0] flt_clr;
    logic [FC_SPAN-1:0] fon;
    logic [FC_SPAN-1:0] fon_q;
    logic [1:0] src;
    logic [1:0] next_owner;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic acc;
    logic wr_en;
    logic pulse_ok;

    // a function is on when any terminal carrying its code is on
    function automatic logic fn_on(input logic [7:0] code, input logic [FC_W*TERMS-1:0] map,
                                   input logic [TERMS-1:0] st);
        logic r;
        r = 1'b0;
        for (int i = 0; i < TERMS; i++) begin
            if (map[i*FC_W +: FC_W] == code && st[i]) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction

    // index of a function code inside the decoded vector
    function automatic int fx(input logic [7:0] code);
        return int'(code - FC_FIRST);
    endfunction

    // two-flop synchroniser; contacts bounce and are unrelated to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= '0;
            sync_b <= '0;
        end else if (ce) begin
            sync_a <= term_in; // RULE24
            sync_b <= sync_a;
        end
    end

    // millisecond tick shared by all filters, saves a wide counter per input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt <= MS_ZERO;
            ms_tick <= 1'b0;
        end else if (ce) begin
            ms_tick <= (ms_cnt == MS_LAST);
            ms_cnt <= (ms_cnt == MS_LAST) ? MS_ZERO : ms_cnt + 1'b1;
        end
    end

    // debounce: a new level must persist filt_ms ticks; zero passes directly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_st <= '0;
            for (int i = 0; i < TERMS; i++) begin
                dbn_cnt[i] <= '0;
            end
        end else if (ce) begin
            for (int i = 0; i < TERMS; i++) begin
                if (sync_b[i] == term_st[i]) begin
                    dbn_cnt[i] <= '0;
                end else if (filt_ms == '0 || (ms_tick && dbn_cnt[i] + FILT_ONE >= filt_ms)) begin
                    term_st[i] <= sync_b[i]; // RULE23
                    dbn_cnt[i] <= '0;
                end else if (ms_tick) begin
                    dbn_cnt[i] <= dbn_cnt[i] + FILT_ONE;
                end
            end
        end
    end

    // decode every code in range; code 31 and codes outside have no consumer
    always_comb begin
        fon = '0;
        for (int k = 0; k < FC_SPAN; k++) begin
            fon[k] = fn_on(FC_FIRST + 8'(k), func_map, term_st); // RULE24 RULE25
        end
    end

    // pulse-train input is only meaningful on the fifth terminal
    assign pulse_ok = term_st[FIFTH_TERM] && func_map[FIFTH_TERM*FC_W +: FC_W] == FC_PULSE; // RULE10

    assign src = cfg[CFG_SRC_LSB +: 2];

    // owner follows the terminal level; code 20 wins over code 37
    always_comb begin
        case (src)
            SRC_TERM: begin
                if (fon[fx(FC_CMD_SW)]) begin
                    next_owner = SRC_PANEL; // RULE1
                end else if (fon[fx(FC_CMD_SW2)]) begin
                    next_owner = SRC_COMM; // RULE16
                end else begin
                    next_owner = SRC_TERM;
                end
            end
            SRC_COMM: begin
                next_owner = fon[fx(FC_CMD_SW)] ? SRC_PANEL : SRC_COMM; // RULE1
            end
            default: begin
                next_owner = SRC_PANEL;
            end
        endcase
    end

    // sticky faults on rising terminal edges; a new fault beats a clear
    assign flt_set[FLT_EXT] = fon[fx(FC_EXT_FLT)] && !fon_q[fx(FC_EXT_FLT)]; // RULE12
    assign flt_set[FLT_U1] = fon[fx(FC_UFLT1)] && !fon_q[fx(FC_UFLT1)]; // RULE21
    assign flt_set[FLT_U2] = fon[fx(FC_UFLT2)] && !fon_q[fx(FC_UFLT2)]; // RULE21
    assign flt_clr = (wr_en && paddr == REG_FAULT) ? pwdata[FLT_N-1:0] : '0;
    assign next_flt = (flt & ~flt_clr) | flt_set;

    // fault state and the code shown, external fault has priority
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flt <= '0;
            fault_stop <= 1'b0;
            fault_code <= NO_FAULT_CODE;
            fault_action <= '0;
        end else if (ce) begin
            flt <= next_flt;
            fault_stop <= |next_flt; // RULE12
            fault_action <= cfg[CFG_UFACT_LSB +: 2]; // RULE21
            if (next_flt[FLT_EXT]) begin
                fault_code <= EXTERNAL_FAULT_CODE;
            end else if (next_flt[FLT_U1]) begin
                fault_code <= USER_FAULT_ONE_CODE;
            end else if (next_flt[FLT_U2]) begin
                fault_code <= USER_FAULT_TWO_CODE;
            end else begin
                fault_code <= NO_FAULT_CODE;
            end
        end
    end

    // event and length counters; an active clear holds them at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fon_q <= '0;
            evt_count <= '0;
            len_count <= '0;
        end else if (ce) begin
            fon_q <= fon;
            if (fon[fx(FC_EVT_CLR)]) begin
                evt_count <= '0; // RULE7
            end else if (fon[fx(FC_EVT_IN)] && !fon_q[fx(FC_EVT_IN)]) begin
                evt_count <= evt_count + CNT_ONE; // RULE6
            end
            if (fon[fx(FC_LEN_CLR)]) begin
                len_count <= '0; // RULE8
            end else if (fon[fx(FC_LEN_IN)] && !fon_q[fx(FC_LEN_IN)]) begin
                len_count <= len_count + CNT_ONE; // RULE8
            end
        end
    end

    // command and frequency control levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_owner <= SRC_TERM;
            ramp_hold <= 1'b0;
            freq_hold <= 1'b0;
            pid_pause <= 1'b0;
            plc_pause <= 1'b0;
            plc_resume <= 1'b0;
            swing_pause <= 1'b0;
            freq_lock <= 1'b0;
            panel_stop <= 1'b0;
            dc_brake <= 1'b0;
            pulse_train <= 1'b0;
        end else if (ce) begin
            cmd_owner <= next_owner;
            ramp_hold <= fon[fx(FC_RAMP_HOLD)]; // RULE2
            freq_hold <= fon[fx(FC_RAMP_HOLD)] || fon[fx(FC_PID_OFF)]; // RULE2 RULE3
            pid_pause <= fon[fx(FC_PID_OFF)]; // RULE3
            plc_pause <= fon[fx(FC_PLC_PAUSE)]; // RULE4
            plc_resume <= plc_pause && !fon[fx(FC_PLC_PAUSE)]; // RULE4
            swing_pause <= fon[fx(FC_SWING)]; // RULE5
            freq_lock <= fon[fx(FC_FREQ_LOCK)]; // RULE13
            // stop is never gated by the ramp hold
            panel_stop <= fon[fx(FC_EXT_STOP)] && next_owner == SRC_PANEL; // RULE15 RULE2
            dc_brake <= fon[fx(FC_DC_BRAKE)]; // RULE11
            pulse_train <= pulse_ok; // RULE10
        end
    end

    // PID, motor and control mode selections
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pid_reverse <= 1'b0;
            pid_int_freeze <= 1'b0;
            x_preset <= 1'b0;
            y_preset <= 1'b0;
            motor_sel <= '0;
            pid_set_two <= 1'b0;
            torque_mode <= 1'b0;
        end else if (ce) begin
            pid_reverse <= cfg[CFG_PIDDIR_BIT] ^ fon[fx(FC_PID_REV)]; // RULE14
            pid_int_freeze <= fon[fx(FC_INT_FRZ)]; // RULE17
            x_preset <= fon[fx(FC_X_PRESET)]; // RULE18
            y_preset <= fon[fx(FC_Y_PRESET)]; // RULE18
            motor_sel <= {fon[fx(FC_MOTOR2)], fon[fx(FC_MOTOR1)]}; // RULE19
            pid_set_two <= cfg[CFG_PIDMODE_LSB +: 2] == PID_MODE_TERM && fon[fx(FC_PID_SET)]; // RULE20
            // speed inhibit of torque control overrides the swap
            torque_mode <= !fon[fx(FC_TQ_INH)] && (cfg[CFG_CTRL_BIT] ^ fon[fx(FC_SPD_TQ)]); // RULE9 RULE22
        end
    end

    // APB: answer comes one cycle into the access phase
    assign acc = psel && penable && !pready;
    assign wr_en = ce && psel && penable && pready && pwrite;

    // read decode, unmapped addresses flag an error
    always_comb begin
        rd_hit = 1'b1;
        case (paddr)
            REG_FUNC_LO: rd_mux = func_map[31:0];
            REG_FUNC_HI: rd_mux = func_map[63:32];
            REG_CFG: rd_mux = cfg;
            REG_FILT: rd_mux = {22'h000000, filt_ms};
            REG_STAT: rd_mux = {term_st, 3'h0, torque_mode, pid_set_two, motor_sel, y_preset, x_preset,
                                pid_int_freeze, panel_stop, pid_reverse, freq_lock, dc_brake, pulse_train,
                                swing_pause, plc_pause, pid_pause, freq_hold, ramp_hold, 2'h0, cmd_owner};
            REG_FAULT: rd_mux = {16'h0000, fault_code, 5'h00, flt};
            REG_EVT: rd_mux = {16'h0000, evt_count};
            REG_LEN: rd_mux = {16'h0000, len_count};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // bus handshake and read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (ce) begin
            pready <= acc;
            pslverr <= acc && !rd_hit;
            if (acc && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // configuration writes, taken at the edge where pready is sampled high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_map <= {FUNC_RST, FUNC_RST};
            cfg <= CFG_RST;
            filt_ms <= FILT_RST;
        end else if (wr_en) begin
            case (paddr)
                REG_FUNC_LO: func_map[31:0] <= pwdata;
                REG_FUNC_HI: func_map[63:32] <= pwdata;
                REG_CFG: cfg <= {24'h000000, pwdata[7:0]};
                REG_FILT: filt_ms <= pwdata[FILT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_plc_release;
        ce && plc_pause && !fon[fx(FC_PLC_PAUSE)];
    endsequence

    sequence s_evt_pulse;
        ce && fon[fx(FC_EVT_IN)] && !fon_q[fx(FC_EVT_IN)] && !fon[fx(FC_EVT_CLR)];
    endsequence

    sequence s_ext_rise;
        ce && fon[fx(FC_EXT_FLT)] && !fon_q[fx(FC_EXT_FLT)];
    endsequence

    AST_OWNER_PANEL: assert property (ce && src == SRC_TERM && fon[fx(FC_CMD_SW)] |=> cmd_owner == SRC_PANEL) // RULE1
        else $error("code 20 did not give panel ownership");
    AST_OWNER_COMM: assert property (ce && src == SRC_TERM && !fon[fx(FC_CMD_SW)] && fon[fx(FC_CMD_SW2)]
                                     |=> cmd_owner == SRC_COMM) // RULE16
        else $error("code 37 did not give communication ownership");
    AST_HOLD: assert property (ce && (fon[fx(FC_RAMP_HOLD)] || fon[fx(FC_PID_OFF)]) |=> freq_hold) // RULE3
        else $error("frequency hold missing");
    AST_PLC_RESUME: assert property (s_plc_release |=> plc_resume && !plc_pause) // RULE4
        else $error("program resume not pulsed");
    AST_EVT_INC: assert property (s_evt_pulse |=> evt_count == $past(evt_count) + CNT_ONE) // RULE6
        else $error("event counter missed a pulse");
    AST_EVT_CLR: assert property (ce && fon[fx(FC_EVT_CLR)] |=> evt_count == '0) // RULE7
        else $error("event counter not cleared");
    AST_PULSE_FIFTH: assert property (ce && !pulse_ok |=> !pulse_train) // RULE10
        else $error("pulse input honoured off the fifth terminal");
    AST_EXT_FAULT: assert property (s_ext_rise |=> fault_stop && fault_code == EXTERNAL_FAULT_CODE) // RULE12
        else $error("external fault not raised");
    AST_SPEED_FORCE: assert property (ce && fon[fx(FC_TQ_INH)] |=> !torque_mode) // RULE9
        else $error("torque mode while inhibited");
    AST_FILTER: assert property (ce && filt_ms != '0 && !ms_tick |=> $stable(term_st)) // RULE23
        else $error("terminal changed between filter ticks");
    AST_PID_REV: assert property (ce && fon[fx(FC_PID_REV)] |=> pid_reverse != cfg[CFG_PIDDIR_BIT]) // RULE14
        else $error("PID direction not inverted");
endmodule

//--- tb/ifd_switches.sv
// Purpose: model of the contacts wired to the input terminals
// Assumes: a closed contact reads high on its line
// Notes: chatter makes every line flicker each cycle to exercise the filter
`timescale 1ns/100ps
module ifd_switches
    import ifd_pkg::*;
(
    input wire logic pclk,
    input wire logic [TERMS-1:0] level,
    input wire logic chatter,
    output logic [TERMS-1:0] term_in
);
    logic flick = 1'b0;
    // bounce is never stable long enough to pass a filter of 2 ms or more
    always @(posedge pclk) begin
        flick <= ~flick;
    end
    assign term_in = chatter ? (level ^ {TERMS{flick}}) : level;
endmodule

//--- tb/input_terminal_function_decoder_tb.sv
// Purpose: self-checking bench for the terminal function decoder
// Assumes: 4 cycles per ms so the default 10 ms filter is 40 cycles
// Notes: table rows hold {code, terminal, expected level outputs}
`timescale 1ns/100ps
module input_terminal_function_decoder_tb
    import ifd_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, chatter = 1'b0;
    logic [7:0] paddr = 8'h00, sw = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, ramp_hold, freq_hold, pid_pause, plc_pause, plc_resume, swing_pause;
    logic torque_mode, pulse_train, dc_brake, fault_stop, freq_lock, pid_reverse, panel_stop;
    logic pid_int_freeze, x_preset, y_preset, pid_set_two;
    logic [1:0] cmd_owner, fault_action, motor_sel;
    logic [7:0] fault_code, term_in;
    logic [CNT_W-1:0] evt_count, len_count;
    logic [16:0] lv;
    int fails = 0, cmp_count = 0, resumes = 0;
    logic [31:0] rows [20] = '{32'h15018000, 32'h1610C000, 32'h17202000, 32'h18301000, 32'h1E400800,
        32'h1E000000, 32'h20500400, 32'h22600200, 32'h23700100, 32'h24000080, 32'h26100040,
        32'h27200020, 32'h28300010, 32'h29400004, 32'h2A500008, 32'h2B600002, 32'h2E700001,
        32'h1F000000, 32'h13100000, 32'h2F200000};
    assign lv = {ramp_hold, freq_hold, pid_pause, plc_pause, swing_pause, pulse_train, dc_brake, freq_lock,
        pid_reverse, panel_stop, pid_int_freeze, x_preset, y_preset, motor_sel, pid_set_two, torque_mode};
    // 20 MHz clock
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        if (plc_resume === 1'b1) resumes++;
    end
    ifd_switches SW (.pclk(pclk), .level(sw), .chatter(chatter), .term_in(term_in));
    ifd_decoder #(.CYC_PER_MS(4)) DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .term_in(term_in), .cmd_owner(cmd_owner),
        .ramp_hold(ramp_hold), .freq_hold(freq_hold), .pid_pause(pid_pause), .plc_pause(plc_pause),
        .plc_resume(plc_resume), .swing_pause(swing_pause), .evt_count(evt_count), .len_count(len_count),
        .torque_mode(torque_mode), .pulse_train(pulse_train), .dc_brake(dc_brake), .fault_stop(fault_stop),
        .fault_code(fault_code), .fault_action(fault_action), .freq_lock(freq_lock),
        .pid_reverse(pid_reverse), .panel_stop(panel_stop), .pid_int_freeze(pid_int_freeze),
        .x_preset(x_preset), .y_preset(y_preset), .motor_sel(motor_sel), .pid_set_two(pid_set_two));
    // one apb transfer, held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // settle covers sync, unfiltered path and output flop
    task settle(input int n = 6);
        repeat (n) @(posedge pclk);
    endtask
    task setfn(input logic [7:0] c, input logic [3:0] t);
        apb(1'b1, REG_FUNC_LO, (t < 4) ? {24'h0, c} << (8 * t[1:0]) : 32'h0);
        apb(1'b1, REG_FUNC_HI, (t >= 4) ? {24'h0, c} << (8 * t[1:0]) : 32'h0);
    endtask
    task end_sim;
        $display("checks=%0d fails=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #1_000_000;
        fails++;
        end_sim;
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        settle(2);
        chk(cmd_owner, 32'h1);
        chk(lv, 32'h0);
        apb(1'b0, REG_CFG, 32'h0);
        chk(rd, CFG_RST);
        apb(1'b0, REG_FILT, 32'h0);
        chk(rd, 32'h00A);
        // bounce must be rejected, a steady level only after the filter time
        setfn(FC_DC_BRAKE, 4'h0);
        sw <= 8'h01; chatter <= 1'b1;
        settle(60);
        chk(dc_brake, 32'h0);
        chatter <= 1'b0;
        settle(30);
        chk(dc_brake, 32'h0);
        settle(30);
        chk(dc_brake, 32'h1);
        sw <= 8'h00;
        apb(1'b1, REG_FILT, 32'h0);
        apb(1'b1, REG_CFG, 32'h08);
        for (int i = 0; i < 20; i++) begin
            setfn(rows[i][31:24], rows[i][23:20]);
            sw <= 8'h01 << rows[i][23:20];
            settle();
            chk(lv, rows[i][16:0]);
            sw <= 8'h00;
            settle();
        end
        chk(resumes, 32'h1);
        // ownership: terminal source, then communication source
        apb(1'b1, REG_CFG, 32'h01);
        apb(1'b1, REG_FUNC_LO, 32'h00002514);
        sw <= 8'h01; settle();
        chk(cmd_owner, SRC_PANEL);
        sw <= 8'h02; settle();
        chk(cmd_owner, SRC_COMM);
        apb(1'b1, REG_CFG, 32'h02);
        sw <= 8'h01; settle();
        chk(cmd_owner, SRC_PANEL);
        sw <= 8'h00; settle();
        chk(cmd_owner, SRC_COMM);
        // counters: clear, pulses, clear again
        apb(1'b1, REG_FUNC_LO, 32'h1C1B1A19);
        sw <= 8'h0A; settle();
        sw <= 8'h00; settle();
        for (int i = 0; i < 3; i++) begin
            sw <= (i < 2) ? 8'h05 : 8'h01; settle();
            sw <= 8'h00; settle();
        end
        chk(evt_count, 32'h3);
        chk(len_count, 32'h2);
        apb(1'b0, REG_EVT, 32'h0);
        chk(rd, 32'h3);
        sw <= 8'h03; settle();
        chk(evt_count, 32'h0);
        sw <= 8'h0C; settle();
        chk(len_count, 32'h0);
        // faults and their action setting
        apb(1'b1, REG_CFG, 32'h40);
        apb(1'b1, REG_FUNC_LO, 32'h002D2C21);
        sw <= 8'h04; settle();
        chk({fault_stop, fault_action, fault_code}, 32'h61C);
        sw <= 8'h01; settle();
        chk(fault_code, EXTERNAL_FAULT_CODE);
        sw <= 8'h00;
        apb(1'b1, REG_FAULT, 32'h7);
        settle(3);
        chk({fault_stop, fault_code}, 32'h0);
        sw <= 8'h02; settle();
        chk(fault_code, USER_FAULT_ONE_CODE);
        sw <= 8'h00;
        // torque default, inhibited, then swapped
        apb(1'b1, REG_CFG, 32'h80);
        apb(1'b1, REG_FUNC_LO, 32'h00002E1D);
        settle();
        chk(torque_mode, 32'h1);
        sw <= 8'h01; settle();
        chk(torque_mode, 32'h0);
        sw <= 8'h02; settle();
        chk(torque_mode, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(er, 32'h1);
        chk(rd, 32'h0);
        // mid-run reset must clear sticky faults and restore register defaults
        presetn <= 1'b0;
        settle(2);
        chk({cmd_owner, fault_stop, fault_code}, 32'h200);
        presetn <= 1'b1;
        apb(1'b0, REG_FUNC_LO, 32'h0);
        chk(rd, FUNC_RST);
        end_sim;
    end
endmodule
